// ### rtl/reset_seq_pkg.sv
package reset_seq_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [11:0] SW_RESET_TRIGGER_OFS = 12'h000;  // software reset trigger
    localparam logic [11:0] CAUSE_FLAGS_0_OFS    = 12'h004;  // persistent reset causes
    localparam logic [11:0] WATCHDOG_CONFIG_OFS  = 12'h008;  // watchdog enable
    localparam logic [11:0] TEST_CTRL_CONFIG_OFS = 12'h00c;  // cause-flag visibility
    localparam logic [11:0] SEQ_STATUS_OFS       = 12'h010;  // sequencer state, live resets

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SW_RESET_BIT     = 0;  // trigger bit
    localparam int WDT_CAUSE_BIT    = 3;  // watchdog cause
    localparam int EXT_CAUSE_BIT    = 4;  // external cause
    localparam int SW_CAUSE_BIT     = 5;  // software cause
    localparam int WDT_ENABLE_BIT   = 4;  // watchdog enable
    localparam int CAUSE_VIS_BIT    = 4;  // reset-status enable in test control

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TRIGGER_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] WDTCFG_RESET  = 8'h00;
    localparam logic [7:0] TSTCFG_RESET  = 8'h00;

    // ----------------------------------------------------------------
    // timing at 10 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int LATCH_LOAD_US   = 10;   // longest latch load time
    localparam int HOLDOFF_US      = 20;   // hold-off duration
    localparam int LATCH_LOAD_CYC  = (LATCH_LOAD_US * 1000) / CLK_PERIOD_NS;
    localparam int HOLDOFF_CYC     = (HOLDOFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // main oscillator speed choices
    localparam logic OSC_12MHZ = 1'b0;
    localparam logic OSC_48MHZ = 1'b1;
    localparam logic [31:0] USER_START_ADDR = 32'h0000_0000;  // first fetch address

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER   = 3'b000,  // waiting for supplies
        ST_LATCH   = 3'b001,  // nonvolatile latch load
        ST_RESET   = 3'b010,  // held in reset
        ST_HOLDOFF = 3'b011,  // hold-off counting
        ST_BOOT    = 3'b100,  // boot configuration
        ST_DEBUG   = 3'b101,  // debug port entry
        ST_USER    = 3'b110   // user mode
    } seq_state_t;

    // ----------------------------------------------------------------
    // bundled inputs
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] supplyGood;   // four supply-good levels
        logic       preciseReady; // precise power reset settled
        logic       bandgapReady; // bandgap settled
    } supply_t;

    typedef struct packed {
        logic done;     // boot configuration finished
        logic sumBad;   // checksum mismatch
    } boot_t;

endpackage

`default_nettype wire

// ### rtl/reset_boot_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module reset_boot_sequencer
    import reset_seq_pkg::*;
#(
    parameter int LATCH_CYCLES   = LATCH_LOAD_CYC,   // latch load length
    parameter int HOLDOFF_CYCLES = HOLDOFF_CYC       // hold-off length
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // reset sources
    input  wire reset_seq_pkg::supply_t supply,
    input  wire logic                   externalResetDedicated_n,
    input  wire logic                   externalResetShared_n,
    input  wire logic                   hasDedicatedPin,
    input  wire logic                   latchSharedResetEn,
    input  wire logic                   watchdogExpired,
    input  wire logic                   sleepMode,
    input  wire logic                   hibernateMode,
    input  wire logic                   dmaTriggerWrite,
    input  wire logic                   mainOscSel,
    // boot
    input  wire reset_seq_pkg::boot_t   boot,
    input  wire logic                   debugAcquirePinA,
    input  wire logic                   debugAcquirePinB,
    // outputs
    output logic                        systemReset,
    output logic                        latchLoad,
    output logic                        fastOscActive,
    output logic                        mainOscFast,
    output logic                        busClockRun,
    output logic                        bootActive,
    output logic                        debugEntry,
    output logic                        cpuRun,
    output logic      [31:0]            fetchAddr
);
    import reset_seq_pkg::*;

    // ----------------------------------------------------------------
    // external reset pin selection and synchronisers
    // ----------------------------------------------------------------
    // shared pin only counts when the latch enables it
    wire extPinLow = (hasDedicatedPin & ~externalResetDedicated_n)
                   | (latchSharedResetEn & ~externalResetShared_n);

    logic [1:0] extSync;     // external reset level, two stages
    logic [1:0] dbgASync;    // debug pin a
    logic [1:0] dbgBSync;    // debug pin b
    logic       dbgAPrev;    // last synced level of pin a
    logic       dbgBPrev;    // last synced level of pin b
    logic [3:0] supSync0;    // first supply stage
    logic [3:0] supSync1;    // second supply stage
    logic [1:0] rdySync;     // bandgap and precise ready, two stages

    // two flops before anything reads a pin
    always_ff @(posedge clk) begin
        extSync  <= {extSync[0], extPinLow};
        dbgASync <= {dbgASync[0], debugAcquirePinA};
        dbgBSync <= {dbgBSync[0], debugAcquirePinB};
        supSync0 <= supply.supplyGood;
        supSync1 <= supSync0;
        rdySync  <= {rdySync[0], supply.bandgapReady & supply.preciseReady};
        dbgAPrev <= dbgASync[1];
        dbgBPrev <= dbgBSync[1];
    end

    wire extHeld     = extSync[1];
    wire allSupplies = &supSync1;

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    seq_state_t state;           // sequencer state
    seq_state_t next_state;
    logic [15:0] count;          // shared cycle counter
    logic [7:0]  causeFlags;     // persistent cause flags
    logic [7:0]  testCfg;        // test control config
    logic        wdtEnable;      // sticky watchdog enable
    logic        swPending;      // software reset request
    logic        dbgSeen;        // toggle seen during boot

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    wire powerOn   = rst | ~allSupplies;
    wire wdtReset  = wdtEnable & watchdogExpired & ~hibernateMode;
    wire swReset   = swPending;
    wire sumReset  = (state == ST_BOOT) & boot.sumBad;
    wire anyReset  = powerOn | wdtReset | swReset | extHeld | sumReset;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire access   = psel & penable;
    wire wrAcc    = access & pwrite;
    wire selTrig  = paddr == SW_RESET_TRIGGER_OFS;
    wire selFlags = paddr == CAUSE_FLAGS_0_OFS;
    wire selWdt   = paddr == WATCHDOG_CONFIG_OFS;
    wire selTst   = paddr == TEST_CTRL_CONFIG_OFS;
    wire selStat  = paddr == SEQ_STATUS_OFS;
    wire mapped   = selTrig | selFlags | selWdt | selTst | selStat;
    wire visible  = testCfg[CAUSE_VIS_BIT];
    // software trigger from processor or dma, not in sleep
    wire trigWr   = ((wrAcc & selTrig & pwdata[SW_RESET_BIT]) | dmaTriggerWrite)
                  & ~sleepMode;
    wire flagsAcc = access & selFlags & visible;

    wire [31:0] rdMux =
        selTrig  ? 32'h0000_0000 :
        selFlags ? (visible ? {24'h00_0000, causeFlags} : 32'h0000_0000) :
        selWdt   ? {27'h000_0000, wdtEnable, 4'h0} :
        selTst   ? {24'h00_0000, testCfg} :
        selStat  ? {26'h000_0000, extHeld, powerOn, 1'b0, state} :
                   32'h0000_0000;

    // no wait cycle: answer registered on the edge that ends setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= rdMux;
        end
    end

    // ----------------------------------------------------------------
    // cause flags: power-on clears, events set, access while visible clears watchdog
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (powerOn) begin
            causeFlags <= FLAGS_RESET;
        end else begin
            if (wdtReset)
                causeFlags[WDT_CAUSE_BIT] <= 1'b1;
            else if (flagsAcc)
                causeFlags[WDT_CAUSE_BIT] <= 1'b0;
            if (swReset)
                causeFlags[SW_CAUSE_BIT] <= 1'b1;
            else if (flagsAcc && wrAcc && !pwdata[SW_CAUSE_BIT])
                causeFlags[SW_CAUSE_BIT] <= 1'b0;
            if (extHeld)
                causeFlags[EXT_CAUSE_BIT] <= 1'b1;
            else if (flagsAcc && wrAcc && !pwdata[EXT_CAUSE_BIT])
                causeFlags[EXT_CAUSE_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // watchdog enable: sticky, survives its own reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (anyReset && !wdtReset)
            wdtEnable <= WDTCFG_RESET[WDT_ENABLE_BIT];
        else if (wrAcc && selWdt && pwdata[WDT_ENABLE_BIT])
            wdtEnable <= 1'b1;
    end

    // ----------------------------------------------------------------
    // test control and software trigger
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (anyReset) begin
            testCfg   <= TSTCFG_RESET;
            swPending <= 1'b0;
        end else begin
            swPending <= trigWr;
            if (wrAcc && selTst)
                testCfg <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    wire countDone = count == 16'h0000;
    wire ready     = rdySync[1];
    wire toggled   = (dbgASync[1] ^ dbgAPrev) & (dbgBSync[1] ^ dbgBPrev);

    always_comb begin
        next_state = state;
        case (state)
            ST_POWER:   next_state = ST_LATCH;
            ST_LATCH:   if (countDone) next_state = ST_RESET;
            ST_RESET:   if (!extHeld) next_state = ST_HOLDOFF;
            ST_HOLDOFF: if (countDone) next_state = ready ? ST_BOOT : ST_RESET;
            ST_BOOT:    if (boot.done) next_state = dbgSeen ? ST_DEBUG : ST_USER;
            ST_DEBUG:   next_state = ST_DEBUG;
            ST_USER:    next_state = ST_USER;
            default:    next_state = ST_POWER;
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer registers; any reset restarts at the right point
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (powerOn) begin
            state <= ST_POWER;
            count <= 16'(LATCH_CYCLES - 1);
        end else if (anyReset) begin
            state <= ST_RESET;
            count <= 16'(HOLDOFF_CYCLES - 1);
        end else begin
            state <= next_state;
            if (next_state != state)
                count <= (next_state == ST_HOLDOFF) ? 16'(HOLDOFF_CYCLES - 1)
                                                    : 16'(LATCH_CYCLES - 1);
            else if (!countDone)
                count <= count - 16'h0001;
        end
    end

    // debug toggle latch during boot
    always_ff @(posedge clk) begin
        if (anyReset || state != ST_BOOT)
            dbgSeen <= 1'b0;
        else if (toggled)
            dbgSeen <= 1'b1;
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            systemReset   <= 1'b1;
            latchLoad     <= 1'b0;
            fastOscActive <= 1'b1;
            mainOscFast   <= OSC_12MHZ;
            busClockRun   <= 1'b0;
            bootActive    <= 1'b0;
            debugEntry    <= 1'b0;
            cpuRun        <= 1'b0;
            fetchAddr     <= USER_START_ADDR;
        end else begin
            systemReset   <= anyReset || state < ST_BOOT;
            latchLoad     <= state == ST_LATCH;
            fastOscActive <= state < ST_BOOT;
            mainOscFast   <= (state >= ST_BOOT) ? mainOscSel : OSC_12MHZ;
            busClockRun   <= state >= ST_BOOT;
            bootActive    <= state == ST_BOOT;
            debugEntry    <= state == ST_DEBUG;
            cpuRun        <= state == ST_USER;
            fetchAddr     <= USER_START_ADDR;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    or_reset_a: assert property (@(posedge clk) disable iff (rst)
        anyReset |=> systemReset) else $error("reset source not seen");
    wdt_sticky_a: assert property (@(posedge clk) disable iff (rst)
        wdtEnable && !anyReset |=> wdtEnable) else $error("enable fell");
    wdt_keep_a: assert property (@(posedge clk) disable iff (rst)
        wdtReset && !powerOn |=> wdtEnable) else $error("enable lost");
    wdt_flag_a: assert property (@(posedge clk) disable iff (rst)
        wdtReset && !powerOn |=> causeFlags[WDT_CAUSE_BIT]) else $error("wdt flag");
    sw_flag_a: assert property (@(posedge clk) disable iff (rst)
        swReset && !powerOn |=> causeFlags[SW_CAUSE_BIT]) else $error("sw flag");
    ext_flag_a: assert property (@(posedge clk) disable iff (rst)
        extHeld && !powerOn |=> causeFlags[EXT_CAUSE_BIT]) else $error("ext flag");
    por_clear_a: assert property (@(posedge clk)
        powerOn |=> causeFlags == 8'h00) else $error("flags kept");
    ext_hold_a: assert property (@(posedge clk) disable iff (rst)
        extHeld |=> state == ST_RESET || state == ST_POWER) else $error("left reset");
    user_pc_a: assert property (@(posedge clk) disable iff (rst)
        cpuRun |-> fetchAddr == 32'h0000_0000) else $error("fetch addr");
    sum_rst_a: assert property (@(posedge clk) disable iff (rst)
        sumReset |=> ##1 systemReset) else $error("checksum");

endmodule // reset_boot_sequencer

`default_nettype wire

// ### sim/pin_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------
// external reset driver and debug host
// --------------------------------------------------------
module pin_host_model (
    input  wire logic clk,          // bench clock
    input  wire logic holdReset,    // pull the reset pins low
    input  wire logic toggleDebug,  // run an acquire attempt
    output logic      resetDed_n,   // dedicated reset pin
    output logic      resetShr_n,   // shared reset pin
    output logic      pinA,         // debug acquire pin a
    output logic      pinB          // debug acquire pin b
);
    // released reset pins are driven high
    assign resetDed_n = !holdReset;
    assign resetShr_n = !holdReset;
    // both acquire pins toggle together, idle low otherwise
    always_ff @(posedge clk) begin
        if (toggleDebug) begin
            pinA <= !pinA;
            pinB <= !pinB;
        end else begin
            pinA <= 1'b0;
            pinB <= 1'b0;
        end
    end
endmodule // pin_host_model
`default_nettype wire

// ### sim/reset_boot_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_boot_sequencer_tb;
    import reset_seq_pkg::*;
    // --------------------------------------------------------
    // signals
    // --------------------------------------------------------
    localparam int CPU = 0, SRST = 1, BOOTA = 2, DBG = 3;  // await selectors
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, fetchAddr, seed;
    supply_t     supply;
    boot_t       boot;
    logic        extDed_n, extShr_n, dbgA, dbgB, holdReset, toggleDebug;
    logic        watchdogExpired, sleepMode, hibernateMode, dmaTriggerWrite, mainOscSel;
    logic        systemReset, latchLoad, fastOscActive, mainOscFast;
    logic        busClockRun, bootActive, debugEntry, cpuRun;
    int          fails, comparisons;
    // short counts keep the run brief
    reset_boot_sequencer #(.LATCH_CYCLES(4), .HOLDOFF_CYCLES(4)) uut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .supply, .externalResetDedicated_n(extDed_n), .externalResetShared_n(extShr_n),
        .hasDedicatedPin(1'b1), .latchSharedResetEn(1'b1), .watchdogExpired, .sleepMode,
        .hibernateMode, .dmaTriggerWrite, .mainOscSel, .boot, .debugAcquirePinA(dbgA),
        .debugAcquirePinB(dbgB), .systemReset, .latchLoad, .fastOscActive, .mainOscFast,
        .busClockRun, .bootActive, .debugEntry, .cpuRun, .fetchAddr);
    pin_host_model host (.clk, .holdReset, .toggleDebug, .resetDed_n(extDed_n),
        .resetShr_n(extShr_n), .pinA(dbgA), .pinB(dbgB));
    always #50 clk = !clk;
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // expected cause byte from watchdog, external, software events
    function automatic logic [31:0] flags(input logic w, input logic e, input logic s);
        return {26'h0, s, e, w, 3'h0};
    endfunction
    function automatic logic pick(input int k);
        return k == CPU ? cpuRun : k == SRST ? systemReset : k == BOOTA ? bootActive : debugEntry;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            fails++;
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask
    // bounded wait for a chosen output to go high
    task automatic await(input int k);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pick(k) !== 1'b1 && n < 300);
        chk(32'(pick(k)), 32'h1);
    endtask
    task automatic boot_ok();
        await(CPU);
        chk(fetchAddr, USER_START_ADDR);
        chk(32'(mainOscFast), 32'(mainOscSel));
        chk(32'(busClockRun), 32'h1);
    endtask
    // --------------------------------------------------------
    // watchdog against hangs
    // --------------------------------------------------------
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        end_of_test();
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        clk = 0;
        rst = 1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        supply = '1;
        boot = 2'b10;
        {holdReset, toggleDebug, watchdogExpired, sleepMode} = '0;
        {hibernateMode, dmaTriggerWrite} = '0;
        seed = 32'h12eb;
        mainOscSel = seed[0];
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        boot_ok();
        rd(SW_RESET_TRIGGER_OFS, 32'h0);
        rd(WATCHDOG_CONFIG_OFS, 32'h0);
        rd(TEST_CTRL_CONFIG_OFS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk(32'(err), 32'h1);
        // random trigger writes with bit 0 clear leave the device running
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            apb(1'b1, SW_RESET_TRIGGER_OFS, seed & 32'hffff_fffe);
        end
        // dma trigger while asleep is ignored
        sleepMode <= 1'b1;
        @(posedge clk) dmaTriggerWrite <= 1'b1;
        @(posedge clk) dmaTriggerWrite <= 1'b0;
        repeat (4) @(negedge clk);
        chk(32'(systemReset), 32'h0);
        @(posedge clk) sleepMode <= 1'b0;
        // sticky watchdog enable, ignored expiry in hibernate
        apb(1'b1, WATCHDOG_CONFIG_OFS, 32'h10);
        apb(1'b1, WATCHDOG_CONFIG_OFS, 32'h0);
        rd(WATCHDOG_CONFIG_OFS, 32'h10);
        hibernateMode <= 1'b1;
        @(posedge clk) watchdogExpired <= 1'b1;
        @(posedge clk) watchdogExpired <= 1'b0;
        repeat (4) @(negedge clk);
        chk(32'(systemReset), 32'h0);
        @(posedge clk) hibernateMode <= 1'b0;
        @(posedge clk) watchdogExpired <= 1'b1;
        @(posedge clk) watchdogExpired <= 1'b0;
        await(SRST);
        boot_ok();
        rd(WATCHDOG_CONFIG_OFS, 32'h10);
        apb(1'b1, TEST_CTRL_CONFIG_OFS, 32'h10);
        rd(CAUSE_FLAGS_0_OFS, flags(1, 0, 0));
        rd(CAUSE_FLAGS_0_OFS, flags(0, 0, 0));
        // software trigger from the bus, random oscillator choice
        seed = xs(seed);
        mainOscSel <= seed[0];
        apb(1'b1, SW_RESET_TRIGGER_OFS, 32'h1);
        await(SRST);
        boot_ok();
        rd(WATCHDOG_CONFIG_OFS, 32'h0);
        rd(CAUSE_FLAGS_0_OFS, 32'h0);
        apb(1'b1, TEST_CTRL_CONFIG_OFS, 32'h10);
        rd(CAUSE_FLAGS_0_OFS, flags(0, 0, 1));
        // external hold, late bandgap, then a debug acquire
        boot.done <= 1'b0;
        supply.bandgapReady <= 1'b0;
        holdReset <= 1'b1;
        repeat (8 + seed[3:0]) @(negedge clk);
        chk(32'(systemReset), 32'h1);
        chk(32'(fastOscActive), 32'h1);
        @(posedge clk) holdReset <= 1'b0;
        repeat (30) @(negedge clk);
        chk(32'(systemReset), 32'h1);
        @(posedge clk) supply.bandgapReady <= 1'b1;
        await(BOOTA);
        @(posedge clk) toggleDebug <= 1'b1;
        repeat (6) @(posedge clk);
        boot.done <= 1'b1;
        await(DBG);
        // checksum failure in boot brings reset back
        @(posedge clk) toggleDebug <= 1'b0;
        holdReset <= 1'b1;
        repeat (5) @(posedge clk);
        holdReset <= 1'b0;
        boot.sumBad <= 1'b1;
        await(BOOTA);
        await(SRST);
        @(posedge clk) boot <= 2'b10;
        boot_ok();
        apb(1'b1, TEST_CTRL_CONFIG_OFS, 32'h10);
        rd(CAUSE_FLAGS_0_OFS, flags(0, 1, 1));
        // power-on clears every cause
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        boot_ok();
        apb(1'b1, TEST_CTRL_CONFIG_OFS, 32'h10);
        rd(CAUSE_FLAGS_0_OFS, 32'h0);
        end_of_test();
    end
endmodule // reset_boot_sequencer_tb
`default_nettype wire
